// File: hdl/bdc_reg_map.vh
`ifndef BDC_REG_MAP_VH
`define BDC_REG_MAP_VH
// register offsets (byte addresses on the plain register port)
`define BDC_ADDR_W 8
`define BDC_OFF_DEVCTL 8'h92
`define BDC_OFF_DIAG 8'h93
`define BDC_OFF_STAT 8'h94
`define BDC_OFF_IRQFLAG 8'h95
`define BDC_OFF_IDENT 8'h00
// reset values
`define BDC_DEVCTL_RST 8'h66
`define BDC_DIAG_RST 8'h60
`define BDC_ZERO8 8'h00
`define BDC_ONES32 32'hFFFFFFFF
`define BDC_ZERO32 32'h00000000
`define BDC_ZERO2 2'h0
`define BDC_OFF 1'b0
`define BDC_ON 1'b1
// number of card sockets
`define BDC_SOCKETS 2
// device control fields
`define BDC_DC_LOCK 7
`define BDC_DC_LVCAP 6
`define BDC_DC_LEGIO 5
`define BDC_DC_RSVD 4
`define BDC_DC_TEST 3
`define BDC_DC_MODE_HI 2
`define BDC_DC_MODE_LO 1
`define BDC_DC_TEST0 0
// writable mask of device control (bit 4 held zero)
`define BDC_DC_WMASK 8'hEF
// diagnostic fields
`define BDC_DG_IDMASK 7
`define BDC_DG_RO1 6
`define BDC_DG_CSC 5
`define BDC_DG_DTDIS 4
`define BDC_DG_RETX 3
`define BDC_DG_CDIS 2
`define BDC_DG_HDIS 1
`define BDC_DG_ZV 0
`define BDC_DG_RO1_MASK 8'h40
// interrupt modes
`define BDC_MODE_PAR 2'h0
`define BDC_MODE_RSVD 2'h1
`define BDC_MODE_SER_PAR 2'h2
`define BDC_MODE_SER 2'h3
// legacy register fields
`define BDC_L803_BIT 4
`define BDC_L805_NIB 4'h0
// retry latency and discard exponents
`define BDC_RETRY_SHORT 7'h10
`define BDC_RETRY_LONG 7'h40
`define BDC_DISC_SHORT 4'hA
`define BDC_DISC_LONG 4'hF
`endif

// File: hdl/bdc_regs.v
// Operation
// - lock bit set: socket power-down requests refused while in D3.
// - force bit reports socket 3-V capable when 1, not when 0; resets 1.
// - device control bit 5 is read/write diagnostic, resets to 1.
// - device control bit 4 reads 0, writes ignored.
// - mode 00 parallel, 01 reserved, 10 serial plus INTA/INTB, 11 serial.
// - one device control store shared by both socket functions.
// - identity mask 1 makes vendor/device identity reads return all ones.
// - diagnostic bit 6 read-only, always 1.
// - status change routing picks legacy 803 bit 4 or 805 nibble test.
// - diagnostic bit 4 disables delayed transactions.
// - diagnostic bit 3 extends retry latency limit from 16 to 64.
// - diagnostic bit 2 selects card-side discard timer 2^10 or 2^15.
// - diagnostic bit 1 selects host-side discard timer 2^10 or 2^15.
// - diagnostic bit 0: 0 enables new video register model, 1 disables.
// - per-socket function irq flag set by card, cleared by writing 1.
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
`include "bdc_reg_map.vh"
module bdc_regs (
   input wire ref_clk_i,
   input wire sys_rst_i,
   input wire [7:0] reg_addr_i,
   input wire [7:0] reg_wdata_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   input wire reg_func_i,
   output reg [7:0] reg_rdata_o,
   output reg [31:0] ident_rdata_o,
   input wire [31:0] ident_true_i,
   input wire ident_rd_i,
   input wire in_d3_i,
   input wire pwr_down_req_i,
   output reg pwr_down_ok_o,
   output reg socket_power_lock_o,
   output reg low_volt_capable_o,
   output reg diag_legacy_io_option_o,
   output reg [1:0] irq_mode_o,
   output reg test_bits_o,
   input wire legacy_803_bit_i,
   input wire [3:0] legacy_805_nib_i,
   output reg csc_to_host_o,
   output reg retry_disable_o,
   output reg [6:0] retry_limit_o,
   output reg [3:0] card_discard_exp_o,
   output reg [3:0] host_discard_exp_o,
   output reg video_new_model_o,
   input wire [1:0] card_irq_i,
   output reg [1:0] card_function_irq_flag_o
);
   // device control and diagnostic stores, single copy for both functions
   reg [7:0] devctl_r;
   reg [7:0] diag_r;
   // bus timing: a strobe is taken at the rising edge it stands on;
   // read data appear one cycle later and stand for that cycle only;
   // a write is visible to a read that follows it with no gap;
   // derived outputs follow a register change one cycle later;
   // the function select is ignored, since every bit lives in one store
   wire [1:0] irq_flag_r;
   reg [7:0] rdata_nxt;
   reg [1:0] mode_nxt;
   reg pwr_nxt;
   reg csc_nxt;
   wire wr_dc;
   wire wr_dg;
   wire wr_flag;
   wire dc_lock;
   wire dg_csc;
   wire dg_retx;
   wire dg_cdis;
   wire dg_hdis;

   // decode of a write to one register
   function hit;
      input [7:0] addr;
      input [7:0] off;
      input stb;
      begin
         hit = stb && (addr == off);
      end
   endfunction

   // discard timer exponent for one side: short when the select is set
   function [3:0] disc_exp;
      input sel;
      begin
         if (sel)
            disc_exp = `BDC_DISC_SHORT;
         else
            disc_exp = `BDC_DISC_LONG;
      end
   endfunction

   // function select does not matter: both functions reach the same store
   assign wr_dc = hit(reg_addr_i, `BDC_OFF_DEVCTL, reg_wr_i);
   assign wr_dg = hit(reg_addr_i, `BDC_OFF_DIAG, reg_wr_i);
   assign wr_flag = hit(reg_addr_i, `BDC_OFF_IRQFLAG, reg_wr_i);
   assign dc_lock = devctl_r[`BDC_DC_LOCK];
   assign dg_csc = diag_r[`BDC_DG_CSC];
   assign dg_retx = diag_r[`BDC_DG_RETX];
   assign dg_cdis = diag_r[`BDC_DG_CDIS];
   assign dg_hdis = diag_r[`BDC_DG_HDIS];

   // register writes; bit 4 masked to zero, diag bit 6 forced one
   always @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
      begin
         devctl_r <= `BDC_DEVCTL_RST;
         diag_r <= `BDC_DIAG_RST;
      end
      else
      begin
         if (wr_dc)
            devctl_r <= reg_wdata_i & `BDC_DC_WMASK;
         if (wr_dg)
            diag_r <= reg_wdata_i | `BDC_DG_RO1_MASK;
      end
   end

   // per socket: two-stage sync of the card interrupt, then a sticky flag;
   // set wins over a write-one clear in the same cycle
   genvar s;
   generate
      for (s = 0; s < `BDC_SOCKETS; s = s + 1)
      begin : g_sock
         reg irq_s1_r;
         reg irq_s2_r;
         reg flag_r;
         reg flag_nxt;

         // only the second stage is read by logic
         always @(posedge ref_clk_i)
         begin
            if (sys_rst_i)
            begin
               irq_s1_r <= `BDC_OFF;
               irq_s2_r <= `BDC_OFF;
               flag_r <= `BDC_OFF;
            end
            else
            begin
               irq_s1_r <= card_irq_i[s];
               irq_s2_r <= irq_s1_r;
               flag_r <= flag_nxt;
            end
         end

         // clear by writing one, then let a pending set override it
         always @*
         begin
            flag_nxt = flag_r;
            if (wr_flag && reg_wdata_i[s])
               flag_nxt = `BDC_OFF;
            if (irq_s2_r)
               flag_nxt = `BDC_ON;
         end

         assign irq_flag_r[s] = flag_r;
      end
   endgenerate

   // interrupt mode decode, reserved code behaves as parallel only
   always @*
   begin
      case (devctl_r[`BDC_DC_MODE_HI:`BDC_DC_MODE_LO])
         `BDC_MODE_PAR: mode_nxt = `BDC_MODE_PAR;
         `BDC_MODE_RSVD: mode_nxt = `BDC_MODE_PAR;
         `BDC_MODE_SER_PAR: mode_nxt = `BDC_MODE_SER_PAR;
         `BDC_MODE_SER: mode_nxt = `BDC_MODE_SER;
         default: mode_nxt = `BDC_MODE_PAR;
      endcase
   end

   // power-down permission and status change routing
   always @*
   begin
      pwr_nxt = pwr_down_req_i && !(dc_lock && in_d3_i);
      if (dg_csc)
         csc_nxt = (legacy_805_nib_i == `BDC_L805_NIB);
      else
         csc_nxt = legacy_803_bit_i;
   end

   // read mux; unmapped offsets read zero
   always @*
   begin
      case (reg_addr_i)
         `BDC_OFF_DEVCTL: rdata_nxt = devctl_r & `BDC_DC_WMASK;
         `BDC_OFF_DIAG: rdata_nxt = diag_r | `BDC_DG_RO1_MASK;
         `BDC_OFF_IRQFLAG: rdata_nxt = {6'h00, irq_flag_r};
         default: rdata_nxt = `BDC_ZERO8;
      endcase
   end

   // read data stand for the one cycle after the strobe, zero otherwise
   always @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
         reg_rdata_o <= `BDC_ZERO8;
      else if (reg_rd_i)
         reg_rdata_o <= rdata_nxt;
      else
         reg_rdata_o <= `BDC_ZERO8;
   end

   // identity capture, masked to all ones when the mask bit is set
   always @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
         ident_rdata_o <= `BDC_ZERO32;
      else if (ident_rd_i)
         ident_rdata_o <= diag_r[`BDC_DG_IDMASK] ? `BDC_ONES32 : ident_true_i;
      else
         ident_rdata_o <= ident_rdata_o;
   end

   // power-down permission
   always @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
         pwr_down_ok_o <= `BDC_OFF;
      else
         pwr_down_ok_o <= pwr_nxt;
   end

   // socket power lock state
   always @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
         socket_power_lock_o <= `BDC_OFF;
      else
         socket_power_lock_o <= dc_lock;
   end

   // forced 3-V capability report
   always @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
         low_volt_capable_o <= `BDC_ON;
      else
         low_volt_capable_o <= devctl_r[`BDC_DC_LVCAP];
   end

   // legacy io diagnostic option
   always @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
         diag_legacy_io_option_o <= `BDC_ON;
      else
         diag_legacy_io_option_o <= devctl_r[`BDC_DC_LEGIO];
   end

   // interrupt signalling mode
   always @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
         irq_mode_o <= `BDC_MODE_SER;
      else
         irq_mode_o <= mode_nxt;
   end

   // test bits, either one set
   always @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
         test_bits_o <= `BDC_OFF;
      else
         test_bits_o <= devctl_r[`BDC_DC_TEST] | devctl_r[`BDC_DC_TEST0];
   end

   // status change routing to the host
   always @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
         csc_to_host_o <= `BDC_OFF;
      else
         csc_to_host_o <= csc_nxt;
   end

   // delayed transaction disable
   always @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
         retry_disable_o <= `BDC_OFF;
      else
         retry_disable_o <= diag_r[`BDC_DG_DTDIS];
   end

   // retry latency limit
   always @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
         retry_limit_o <= `BDC_RETRY_SHORT;
      else
         retry_limit_o <= dg_retx ? `BDC_RETRY_LONG : `BDC_RETRY_SHORT;
   end

   // card-side discard timer exponent
   always @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
         card_discard_exp_o <= `BDC_DISC_LONG;
      else
         card_discard_exp_o <= disc_exp(dg_cdis);
   end

   // host-side discard timer exponent
   always @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
         host_discard_exp_o <= `BDC_DISC_LONG;
      else
         host_discard_exp_o <= disc_exp(dg_hdis);
   end

   // zoomed-video register model, new model while the bit is clear
   always @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
         video_new_model_o <= `BDC_ON;
      else
         video_new_model_o <= !diag_r[`BDC_DG_ZV];
   end

   // copy of the per-socket interrupt flags
   always @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
         card_function_irq_flag_o <= `BDC_ZERO2;
      else
         card_function_irq_flag_o <= irq_flag_r;
   end
endmodule // bdc_regs

// File: testbench/bdc_regs_checker.sv
`timescale 1ns/1ps
`include "bdc_reg_map.vh"
module bdc_regs_checker (
   input wire ref_clk_i,
   input wire sys_rst_i,
   input wire [7:0] reg_addr_i,
   input wire [7:0] reg_wdata_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   input wire [7:0] reg_rdata_o,
   input wire in_d3_i,
   input wire pwr_down_req_i,
   input wire pwr_down_ok_o,
   input wire socket_power_lock_o,
   input wire [1:0] irq_mode_o,
   input wire [6:0] retry_limit_o,
   input wire [3:0] card_discard_exp_o,
   input wire [3:0] host_discard_exp_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i);
   // power-down refused under the lock in the low-power state, and granted outside that state
   a_lock_refuses_down: assert property (
      pwr_down_req_i && in_d3_i && socket_power_lock_o |=> !pwr_down_ok_o)
      else $error("power-down granted while locked");
   a_free_grants_down: assert property (
      pwr_down_req_i && !in_d3_i |=> pwr_down_ok_o) else $error("power-down not granted");
   // write then read back, whichever function is used
   a_devctl_read_back: assert property (
      reg_wr_i && reg_addr_i == `BDC_OFF_DEVCTL ##1 reg_rd_i && reg_addr_i == `BDC_OFF_DEVCTL
      |=> reg_rdata_o == ($past(reg_wdata_i, 2) & `BDC_DC_WMASK)) else $error("devctl readback");
   a_diag_read_back: assert property (
      reg_wr_i && reg_addr_i == `BDC_OFF_DIAG ##1 reg_rd_i && reg_addr_i == `BDC_OFF_DIAG
      |=> reg_rdata_o == ($past(reg_wdata_i, 2) | `BDC_DG_RO1_MASK)) else $error("diag readback");
   a_rsvd_bit_zero: assert property (
      reg_rd_i && reg_addr_i == `BDC_OFF_DEVCTL |=> !reg_rdata_o[`BDC_DC_RSVD])
      else $error("reserved bit set");
   a_mode_never_rsvd: assert property (irq_mode_o != `BDC_MODE_RSVD)
      else $error("reserved mode driven");
   a_retry_limit_legal: assert property (
      retry_limit_o == `BDC_RETRY_SHORT || retry_limit_o == `BDC_RETRY_LONG)
      else $error("retry limit value");
   a_discard_exp_legal: assert property (
      card_discard_exp_o inside {`BDC_DISC_SHORT, `BDC_DISC_LONG}
      && host_discard_exp_o inside {`BDC_DISC_SHORT, `BDC_DISC_LONG}) else $error("discard exp");
endmodule // bdc_regs_checker
bind bdc_regs bdc_regs_checker chk (.*);

// File: testbench/bdc_regs_bench.sv
`timescale 1ns/1ps
`include "bdc_reg_map.vh"
module bdc_regs_bench;
   logic ref_clk_i = 1'h0, sys_rst_i = 1'h1, reg_wr_i = 1'h0, reg_rd_i = 1'h0, reg_func_i = 1'h0;
   logic ident_rd_i = 1'h0, in_d3_i = 1'h0, pwr_down_req_i = 1'h0, legacy_803_bit_i = 1'h0;
   logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
   logic [31:0] ident_rdata_o, ident_true_i = 32'h0BAD5EED; // arbitrary value
   logic [3:0] legacy_805_nib_i = 4'h0, card_discard_exp_o, host_discard_exp_o;
   logic [1:0] card_irq_i = 2'h0, irq_mode_o, card_function_irq_flag_o;
   logic [6:0] retry_limit_o;
   logic pwr_down_ok_o, socket_power_lock_o, low_volt_capable_o, diag_legacy_io_option_o;
   logic test_bits_o, csc_to_host_o, retry_disable_o, video_new_model_o;
   int n_tests = 0, n_mismatch = 0;
   logic fn1 = 1'h0;
   always #2.5 ref_clk_i = ~ref_clk_i;
   bdc_regs uut (.*);
   // compare and count
   task chk(input string n, input logic [31:0] e, input logic [31:0] s);
      n_tests++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("mismatch %s exp %h got %h", n, e, s);
      end
   endtask
   // one bus cycle; the function number comes from fn1, which is set to 1 for only one devctl write
   task op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      reg_wr_i <= w;
      reg_rd_i <= r;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_func_i <= fn1;
   endtask
   task settle;
      repeat (3) @(posedge ref_clk_i);
      #1;
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      op(1'h1, 1'h0, a, d);
      op(1'h0, 1'h0, a, d);
      settle;
   endtask
   task rd(input logic [7:0] a, input logic [7:0] e);
      op(1'h0, 1'h1, a, 8'h00);
      op(1'h0, 1'h0, a, 8'h00);
      #1 chk("rdata", {24'h000000, e}, {24'h000000, reg_rdata_o});
   endtask
   task idr(input logic [31:0] e);
      @(posedge ref_clk_i);
      ident_rd_i <= 1'h1;
      @(posedge ref_clk_i);
      ident_rd_i <= 1'h0;
      #1 chk("ident", e, ident_rdata_o);
   endtask
   task lg(input logic b, input logic [3:0] n);
      @(posedge ref_clk_i);
      legacy_803_bit_i <= b;
      legacy_805_nib_i <= n;
      settle;
   endtask
   task t_reset;
      rd(`BDC_OFF_DEVCTL, `BDC_DEVCTL_RST);
      rd(`BDC_OFF_DIAG, `BDC_DIAG_RST);
      chk("lvcap", 32'h1, low_volt_capable_o);
      chk("legio", 32'h1, diag_legacy_io_option_o);
      chk("mode", `BDC_MODE_SER, irq_mode_o);
      chk("video", 32'h1, video_new_model_o);
   endtask
   task t_devctl;
      for (int m = 0; m < 4; m++)
      begin
         wr(`BDC_OFF_DEVCTL, {5'h00, m[1:0], 1'h0});
         chk("mode", (m == 1) ? 2'h0 : m[1:0], irq_mode_o);
      end
      op(1'h1, 1'h0, `BDC_OFF_DEVCTL, 8'hF6);
      rd(`BDC_OFF_DEVCTL, 8'hE6);
      chk("tbits", 32'h0, test_bits_o);
      fn1 = 1'h1;
      wr(`BDC_OFF_DEVCTL, 8'h84);
      fn1 = 1'h0;
      rd(`BDC_OFF_DEVCTL, 8'h84);
      chk("mode", `BDC_MODE_SER_PAR, irq_mode_o);
      wr(`BDC_OFF_DEVCTL, 8'h00);
      chk("lvcap", 32'h0, low_volt_capable_o);
   endtask
   task t_lock;
      @(posedge ref_clk_i);
      in_d3_i <= 1'h1;
      pwr_down_req_i <= 1'h1;
      settle;
      chk("pwr_ok", 32'h1, pwr_down_ok_o);
      wr(`BDC_OFF_DEVCTL, 8'h80);
      chk("pwr_ok", 32'h0, pwr_down_ok_o);
      @(posedge ref_clk_i);
      in_d3_i <= 1'h0;
      settle;
      chk("pwr_ok", 32'h1, pwr_down_ok_o);
      @(posedge ref_clk_i);
      pwr_down_req_i <= 1'h0;
      wr(`BDC_OFF_DEVCTL, `BDC_DEVCTL_RST);
   endtask
   task t_diag;
      op(1'h1, 1'h0, `BDC_OFF_DIAG, 8'hFF);
      rd(`BDC_OFF_DIAG, 8'hFF);
      chk("rdis", 32'h1, retry_disable_o);
      chk("retry", `BDC_RETRY_LONG, retry_limit_o);
      chk("cexp", `BDC_DISC_SHORT, card_discard_exp_o);
      chk("hexp", `BDC_DISC_SHORT, host_discard_exp_o);
      chk("video", 32'h0, video_new_model_o);
      idr(`BDC_ONES32);
      op(1'h1, 1'h0, `BDC_OFF_DIAG, 8'h00);
      rd(`BDC_OFF_DIAG, `BDC_DG_RO1_MASK);
      idr(ident_true_i);
      chk("cexp", `BDC_DISC_LONG, card_discard_exp_o);
   endtask
   task t_csc;
      wr(`BDC_OFF_DIAG, 8'h20);
      lg(1'h1, 4'h0);
      chk("csc", 32'h1, csc_to_host_o);
      lg(1'h1, 4'h5);
      chk("csc", 32'h0, csc_to_host_o);
      wr(`BDC_OFF_DIAG, 8'h00);
      chk("csc", 32'h1, csc_to_host_o);
      lg(1'h0, 4'h0);
      chk("csc", 32'h0, csc_to_host_o);
   endtask
   task t_flag;
      @(posedge ref_clk_i);
      card_irq_i <= 2'h1;
      repeat (2) settle;
      chk("flag", 32'h1, card_function_irq_flag_o);
      @(posedge ref_clk_i);
      card_irq_i <= 2'h0;
      repeat (2) settle;
      wr(`BDC_OFF_IRQFLAG, 8'h01);
      chk("flag", 32'h0, card_function_irq_flag_o);
      rd(`BDC_OFF_STAT, `BDC_ZERO8);
   endtask
   task tally_and_finish;
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // watchdog, well beyond the roughly 115 cycles the tests need
   initial
   begin
      #20000;
      n_mismatch++;
      tally_and_finish;
   end
   initial
   begin
      repeat (2) @(posedge ref_clk_i);
      sys_rst_i <= 1'h0;
      t_reset;
      t_devctl;
      t_lock;
      t_diag;
      t_csc;
      t_flag;
      tally_and_finish;
   end
endmodule // bdc_regs_bench
